// ==== logic/sram_port_pkg.sv ====
package sram_port_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    localparam logic [16:0] WORD_COUNT = 17'h10000;
    // Pin timing in ns, counts are cycles of the 4 ns clock
    localparam int CLK_PERIOD_NS = 4;
    localparam int ACCESS_TIME_NS = 15;
    localparam int WRITE_PULSE_NS = 15;
    localparam int TURN_TIME_NS = 7;
    localparam logic [3:0] ACCESS_CYCLES =
        4'((ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] WRITE_CYCLES =
        4'((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] TURN_CYCLES =
        4'((TURN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] COUNT_RESET = 4'h0;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [1:0] LANES_RESET = 2'h0;
endpackage : sram_port_pkg

// ==== logic/pin_sync_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface pin_sync_if;
    logic [15:0] raw;
    logic [15:0] synced;
    modport owner (output raw, input synced);
    modport stage (input raw, output synced);
endinterface : pin_sync_if
`default_nettype wire

// ==== logic/pin_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module pin_sync
    import sram_port_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    pin_sync_if.stage port
);
    logic [15:0] first;
    logic [15:0] second;
    logic [15:0] next_first;
    logic [15:0] next_second;

    always_comb
    begin
        next_first = rst_n_in ? port.raw : DATA_RESET;
        next_second = rst_n_in ? first : DATA_RESET;
    end

    always_ff @(posedge mclk_in)
    begin
        first <= next_first;
        second <= next_second;
    end

    assign port.synced = second;
endmodule : pin_sync
`default_nettype wire

// ==== logic/sram_host_port.sv ====
`timescale 1ns/1ns
`default_nettype none
module sram_host_port
    import sram_port_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [15:0] req_addr_in,
    input wire logic [15:0] req_wdata_in,
    input wire logic [1:0] req_lanes_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [15:0] rsp_rdata_out,
    output logic [15:0] word_address_out,
    output logic chip_select_n_out,
    output logic write_strobe_n_out,
    output logic output_enable_n_out,
    output logic lower_lane_select_n_out,
    output logic upper_lane_select_n_out,
    output logic [15:0] data_bus_out,
    output logic data_bus_oe_out,
    input wire logic [15:0] data_bus_in
);
    // ------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------
    pin_sync_if sync_port ();
    assign sync_port.raw = data_bus_in;
    pin_sync u_sync (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .port(sync_port)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        IDLE = 3'b000,
        READ = 3'b001,
        CAPTURE = 3'b010,
        WRITE = 3'b011,
        TURN = 3'b100
    } state_t;

    state_t state;
    state_t next_state;
    logic [3:0] count;
    logic [3:0] next_count;
    logic [15:0] addr;
    logic [15:0] next_addr;
    logic [15:0] wdata;
    logic [15:0] next_wdata;
    logic [1:0] lanes;
    logic [1:0] next_lanes;
    logic [1:0] lane_n;
    logic [1:0] next_lane_n;
    logic [15:0] rdata;
    logic [15:0] next_rdata;
    logic ready;
    logic next_ready;
    logic rsp;
    logic next_rsp;
    logic ce_n;
    logic next_ce_n;
    logic we_n;
    logic next_we_n;
    logic oe_n;
    logic next_oe_n;
    logic drive;
    logic next_drive;

    always_comb
    begin
        next_state = state;
        next_count = count;
        next_addr = addr;
        next_wdata = wdata;
        next_lanes = lanes;
        next_rdata = rdata;
        next_ready = 1'b0;
        next_rsp = 1'b0;
        next_ce_n = 1'b1;
        next_we_n = 1'b1;
        next_oe_n = 1'b1;
        next_drive = 1'b0;
        unique case (state)
            IDLE:
            begin
                next_ready = 1'b1;
                if (ready && req_valid_in && req_lanes_in != 2'h0)
                begin
                    next_ready = 1'b0;
                    next_addr = req_addr_in;
                    next_wdata = req_wdata_in;
                    next_lanes = req_lanes_in;
                    next_count = COUNT_RESET;
                    next_ce_n = 1'b0;
                    if (req_write_in)
                    begin
                        // Write data is driven only with output enable high
                        next_state = WRITE;
                        next_we_n = 1'b0;
                        next_drive = 1'b1;
                    end
                    else
                    begin
                        next_state = READ;
                        next_oe_n = 1'b0;
                    end
                end
            end
            READ:
            begin
                next_ce_n = 1'b0;
                next_oe_n = 1'b0;
                next_count = count + 4'h1;
                // Two extra cycles cover the pin synchroniser
                if (count == ACCESS_CYCLES + 4'h1)
                begin
                    next_state = CAPTURE;
                end
            end
            CAPTURE:
            begin
                next_rdata[7:0] = lanes[0] ? sync_port.synced[7:0] : 8'h00;
                next_rdata[15:8] = lanes[1] ? sync_port.synced[15:8] : 8'h00;
                next_rsp = 1'b1;
                next_count = COUNT_RESET;
                next_state = TURN;
            end
            WRITE:
            begin
                next_ce_n = 1'b0;
                next_count = count + 4'h1;
                if (count == WRITE_CYCLES - 4'h1)
                begin
                    // Strobe rises first; data held one more cycle
                    next_drive = 1'b1;
                    next_count = COUNT_RESET;
                    next_state = TURN;
                end
                else
                begin
                    next_we_n = 1'b0;
                    next_drive = 1'b1;
                end
            end
            TURN:
            begin
                // Deselect lets the device power down and float its bus
                next_count = count + 4'h1;
                if (count == TURN_CYCLES - 4'h1)
                begin
                    next_state = IDLE;
                    next_ready = 1'b1;
                end
            end
            default:
            begin
                next_state = IDLE;
            end
        endcase
        if (!rst_n_in)
        begin
            next_state = IDLE;
            next_count = COUNT_RESET;
            next_addr = ADDR_RESET;
            next_wdata = DATA_RESET;
            next_lanes = LANES_RESET;
            next_rdata = DATA_RESET;
            next_ready = 1'b0;
            next_rsp = 1'b0;
            next_ce_n = 1'b1;
            next_we_n = 1'b1;
            next_oe_n = 1'b1;
            next_drive = 1'b0;
        end
        // Lane pins come from their own flops, not from an inverter
        next_lane_n = ~next_lanes;
    end

    always_ff @(posedge mclk_in)
    begin
        state <= next_state;
        count <= next_count;
        addr <= next_addr;
        wdata <= next_wdata;
        lanes <= next_lanes;
        rdata <= next_rdata;
        ready <= next_ready;
        rsp <= next_rsp;
        ce_n <= next_ce_n;
        we_n <= next_we_n;
        oe_n <= next_oe_n;
        drive <= next_drive;
        lane_n <= next_lane_n;
    end

    assign req_ready_out = ready;
    assign rsp_valid_out = rsp;
    assign rsp_rdata_out = rdata;
    assign word_address_out = addr;
    assign chip_select_n_out = ce_n;
    assign write_strobe_n_out = we_n;
    assign output_enable_n_out = oe_n;
    assign lower_lane_select_n_out = lane_n[0];
    assign upper_lane_select_n_out = lane_n[1];
    assign data_bus_out = wdata;
    assign data_bus_oe_out = drive;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_write_start;
        !chip_select_n_out && !write_strobe_n_out;
    endsequence

    a_write_pulse_width: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        $fell(write_strobe_n_out) |-> s_write_start [*4])
        else $error("write pulse too short");
    a_no_bus_fight: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        data_bus_oe_out |-> output_enable_n_out)
        else $error("host drives while output enabled");
    a_read_no_strobe: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        !output_enable_n_out |-> write_strobe_n_out && !chip_select_n_out)
        else $error("read without select or with strobe");
    a_write_drives_data: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        !write_strobe_n_out |-> data_bus_oe_out)
        else $error("write strobe without data");
    a_lane_one_chosen: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        !chip_select_n_out |->
        !(lower_lane_select_n_out && upper_lane_select_n_out))
        else $error("access with no lane");
    a_read_answers: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        $fell(output_enable_n_out) |-> ##[5:7] rsp_valid_out)
        else $error("read answer late");
    a_addr_stable: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        !chip_select_n_out && !$past(chip_select_n_out) |->
        $stable(word_address_out))
        else $error("address moved during access");
    a_deselect_gap: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        $rose(chip_select_n_out) |-> chip_select_n_out [*2])
        else $error("reselected too soon");
endmodule : sram_host_port
`default_nettype wire

// ==== dv/sram_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module sram_model
    import sram_port_pkg::*;
(
    input wire logic [15:0] addr_in,
    input wire logic cs_n_in,
    input wire logic we_n_in,
    input wire logic oe_n_in,
    input wire logic [1:0] lane_n_in,
    input wire logic [15:0] bus_in,
    output logic [15:0] rdata_out,
    output logic [1:0] drive_out,
    output logic power_down_out
);
    // ------
    // Array
    // ------
    logic [15:0] mem [0:65535];
    logic sel;
    assign sel = !cs_n_in;
    assign power_down_out = !sel;
    // Latches as the strobe rises: address and data are settled then,
    // so pins switching in one time step cannot hit a stale address
    always @(posedge we_n_in)
    begin
        if (sel && !lane_n_in[0])
            mem[addr_in][7:0] <= bus_in[7:0];
        if (sel && !lane_n_in[1])
            mem[addr_in][15:8] <= bus_in[15:8];
    end
    // Data lags by the full access time, enables do not
    assign #(ACCESS_TIME_NS) rdata_out = mem[addr_in];
    assign drive_out = (sel && we_n_in && !oe_n_in) ?
        ~lane_n_in : 2'h0;
endmodule : sram_model
`default_nettype wire

// ==== dv/sram_host_port_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module sram_host_port_tb;
    typedef struct packed {
        logic w;
        logic [15:0] a;
        logic [15:0] d;
        logic [1:0] l;
    } row_t;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic valid = 1'b0;
    logic wr = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic [1:0] lanes = 2'h0;
    logic [7:0] junk = 8'h96;
    logic ready, rsp, cs_n, we_n, oe_n, lb_n, ub_n, hoe, pd;
    logic [15:0] rdata, wa, hdata, mdata;
    logic [1:0] drive;
    wire [15:0] bus;
    int fail_count = 0;
    int tests_run = 0;
    row_t rows [0:11] = '{
        {1'h1, 16'h0000, 16'ha5c3, 2'h3},
        {1'h1, 16'hffff, 16'h1234, 2'h3},
        {1'h1, 16'hffff, 16'habcd, 2'h1},
        {1'h1, 16'h0001, 16'hffff, 2'h3},
        {1'h1, 16'h0001, 16'h5a00, 2'h2},
        {1'h1, 16'h8000, 16'h0f0f, 2'h3},
        {1'h0, 16'h0000, 16'ha5c3, 2'h3},
        {1'h0, 16'hffff, 16'h12cd, 2'h3},
        {1'h0, 16'hffff, 16'h1200, 2'h2},
        {1'h0, 16'h0001, 16'h00ff, 2'h1},
        {1'h0, 16'h0001, 16'h5aff, 2'h3},
        {1'h0, 16'h8000, 16'h0f0f, 2'h3}
    };
    always #2 mclk_in = ~mclk_in;
    // Undriven lanes show a changing pattern, never the last value
    always @(posedge mclk_in)
        junk <= ~junk;
    assign bus[7:0] = hoe ? hdata[7:0] : drive[0] ? mdata[7:0] : junk;
    assign bus[15:8] = hoe ? hdata[15:8] : drive[1] ? mdata[15:8] : junk;
    sram_host_port i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .req_valid_in(valid), .req_write_in(wr), .req_addr_in(addr),
        .req_wdata_in(wdata), .req_lanes_in(lanes), .req_ready_out(ready),
        .rsp_valid_out(rsp), .rsp_rdata_out(rdata), .word_address_out(wa),
        .chip_select_n_out(cs_n), .write_strobe_n_out(we_n),
        .output_enable_n_out(oe_n), .lower_lane_select_n_out(lb_n),
        .upper_lane_select_n_out(ub_n), .data_bus_out(hdata),
        .data_bus_oe_out(hoe), .data_bus_in(bus));
    sram_model i_mem (.addr_in(wa), .cs_n_in(cs_n), .we_n_in(we_n),
        .oe_n_in(oe_n), .lane_n_in({ub_n, lb_n}), .bus_in(bus),
        .rdata_out(mdata), .drive_out(drive), .power_down_out(pd));
    // ------
    // Helpers
    // ------
    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string name, input logic [15:0] exp,
        input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    function automatic logic [15:0] ctl();
        return {9'h0, cs_n, we_n, oe_n, ub_n, lb_n, hoe, ready};
    endfunction : ctl
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1)
        begin
            @(negedge mclk_in);
            n++;
            if (n > 40)
            begin
                fail_count++;
                print_verdict();
            end
        end
    endtask : wait_ready
    task automatic do_reset();
        rst_n_in = 1'b0;
        repeat (10) @(negedge mclk_in);
        chk("reset_pins", 16'h007c, ctl());
        rst_n_in = 1'b1;
    endtask : do_reset
    task automatic do_req(input row_t r);
        int n;
        wait_ready();
        valid = 1'b1;
        wr = r.w;
        addr = r.a;
        wdata = r.d;
        lanes = r.l;
        @(negedge mclk_in);
        valid = 1'b0;
        @(negedge mclk_in);
        chk("pins", {10'h0, !r.w, r.w, ~r.l, r.w, 1'b0}, ctl());
        chk("word_address", r.a, wa);
        chk("power_down", 16'h0000, {15'h0, pd});
        if (r.w)
        begin
            chk("write_data", r.d, hdata);
            repeat (2) @(negedge mclk_in);
            chk("strobe_held", 16'h0000, {15'h0, we_n});
            @(negedge mclk_in);
            chk("strobe_end", {12'h003, ~r.l, 2'h2}, ctl());
        end
        else
        begin
            n = 1;
            while (rsp !== 1'b1 && n < 20)
            begin
                @(negedge mclk_in);
                n++;
            end
            chk("rsp_delay", 16'h0007, 16'(n));
            chk("read_data", r.d, rdata);
        end
    endtask : do_req
    // Host must never drive while the memory drives
    always @(negedge mclk_in)
        if (rst_n_in)
            chk("bus_fight", 16'h0000, {14'h0, hoe ? drive : 2'h0});
    initial
    begin
        do_reset();
        for (int i = 0; i < 12; i++)
            do_req(rows[i]);
        // A request with no lanes must leave the bus idle
        wait_ready();
        valid = 1'b1;
        wr = 1'b1;
        addr = 16'h0000;
        lanes = 2'h0;
        repeat (4) @(negedge mclk_in);
        // Lane pins keep the last access; only the strobes, hoe and ready count here
        chk("no_lanes", 16'h0071, ctl() & 16'h0073);
        chk("idle_power", 16'h0001, {15'h0, pd});
        valid = 1'b0;
        @(negedge mclk_in);
        do_req({1'h0, 16'h0000, 16'ha5c3, 2'h3});
        // Reset in mid-write, then a read must still work
        wait_ready();
        valid = 1'b1;
        wr = 1'b1;
        wdata = 16'h3c3c;
        addr = 16'h0002;
        lanes = 2'h3;
        @(negedge mclk_in);
        valid = 1'b0;
        @(negedge mclk_in);
        do_reset();
        do_req({1'h0, 16'hffff, 16'h12cd, 2'h3});
        print_verdict();
    end
endmodule : sram_host_port_tb
`default_nettype wire
